/* File: verilog/adcseq_map.svh */
// Purpose: constants for the sample/convert sequencer
// Assumes: ref_clk 250 MHz; serial clock and strobe arrive as pins
// Notes: included by the top-level design file only
`ifndef ADCSEQ_MAP_SVH
`define ADCSEQ_MAP_SVH
`define ADCSEQ_CFG_RESET    12'h800
`define ADCSEQ_CFG_CLKSRC   8
`define ADCSEQ_CFG_SHORT    9
`define ADCSEQ_CFG_MODE_HI  6
`define ADCSEQ_CFG_MODE_LO  5
`define ADCSEQ_CFG_SWP_HI   4
`define ADCSEQ_CFG_SWP_LO   3
`define ADCSEQ_CFG_EOC      2
`define ADCSEQ_CMD_WRITE    4'hA
`define ADCSEQ_CMD_READ     4'hE
`define ADCSEQ_CMD_DEFAULT  4'hF
`define ADCSEQ_CMD_BITS     6'h04
`define ADCSEQ_SHORT_END    6'h10
`define ADCSEQ_LONG_END     6'h30
`define ADCSEQ_FRAME_BITS   6'h10
`define ADCSEQ_EXT_DLY_NS   15
`define ADCSEQ_CLK_NS       4
`define ADCSEQ_DIV4         2'h3
`define ADCSEQ_PIN_IDLE     5'h0E
`endif

/* File: verilog/adcseq_pkg.sv */
// Purpose: types for the sample/convert sequencer
// Assumes: nothing
// Notes: states of the sequencer
package adcseq_pkg;
  typedef enum logic [2:0] {ST_IDLE, ST_CMD, ST_SAMPLE, ST_EXT, ST_CONV, ST_WAIT} adcseq_state_t;
  typedef enum logic [1:0] {MD_ONE, MD_REPEAT, MD_SWEEP, MD_RSWEEP} adcseq_mode_t;
endpackage

/* File: verilog/adcseq_sync.sv */
// Purpose: two-flop synchroniser for a group of pin inputs
// Assumes: inputs asynchronous to ref_clk
// Notes: first stage read only by second
`timescale 1ns/10ps
module adcseq_sync #(
  parameter int           W       = 4,
  parameter logic [W-1:0] RST_VAL = '1
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] meta_q;
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          meta_q[i]   <= RST_VAL[i];
          sync_out[i] <= RST_VAL[i];
        end else begin
          meta_q[i]   <= async_in[i];
          sync_out[i] <= meta_q[i];
        end
      end
    end
  endgenerate
endmodule // adcseq_sync

/* File: verilog/adcseq_buf2.sv */
// Purpose: two-entry valid/ready buffer for converted results
// Assumes: one clock
// Notes: full and empty are exact
`timescale 1ns/10ps
module adcseq_buf2 #(
  parameter int W = 4
) (
  input  wire logic         ref_clk,
  input  wire logic         rst,
  input  wire logic         in_valid,
  output logic              in_ready,
  input  wire logic [W-1:0] in_data,
  output logic              out_valid,
  input  wire logic         out_ready,
  output logic      [W-1:0] out_data
);
  logic [W-1:0] mem_q [2];
  logic         wp_q;
  logic         rp_q;
  logic [1:0]   cnt_q;
  logic         push;
  logic         pop;
  assign in_ready  = (cnt_q != 2'h2);
  assign out_valid = (cnt_q != 2'h0);
  assign out_data  = mem_q[rp_q];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      mem_q[0] <= '0;
      mem_q[1] <= '0;
      wp_q     <= 1'b0;
      rp_q     <= 1'b0;
      cnt_q    <= 2'h0;
    end else begin
      if (push) begin
        mem_q[wp_q] <= in_data;
        wp_q        <= ~wp_q;
      end
      if (pop) begin
        rp_q <= ~rp_q;
      end
      cnt_q <= cnt_q + {1'b0, push} - {1'b0, pop};
    end
  end
  a_buf_no_over: assert property (@(posedge ref_clk) disable iff (rst) cnt_q <= 2'h2)
    else $error("buffer overfilled");
endmodule // adcseq_buf2

/* File: verilog/adcseq_top.sv */
// Purpose: sampling and conversion sequencer of a serial multichannel converter
// Assumes: serial clock, chip select, frame sync, strobe and serial_in are pins
// Notes: conversion result data itself is an external input sampled at conversion end
`timescale 1ns/10ps
`include "adcseq_map.svh"
module adcseq_top #(
  parameter int          RES_W      = 14,
  parameter logic [4:0]  CONV_CLKS  = 5'h12,
  parameter logic [7:0]  OSC_DIV    = 8'h26,
  parameter int          QDEPTH     = 8
) (
  input  wire logic             ref_clk,
  input  wire logic             rst,
  input  wire logic             sclk,
  input  wire logic             cs_n,
  input  wire logic             frame_sync,
  input  wire logic             ext_sample_trigger_n,
  input  wire logic             serial_in,
  input  wire logic [RES_W-1:0] adc_result,
  input  wire logic             res_ready,
  output logic                  res_valid,
  output logic      [RES_W-1:0] res_data,
  output logic      [2:0]       sample_channel,
  output logic                  sampling,
  output logic                  conversion_done_n,
  output logic                  int_n,
  output logic      [11:0]      cfg_word_out
);
  localparam int EXT_CYC = (`ADCSEQ_EXT_DLY_NS + `ADCSEQ_CLK_NS - 1) / `ADCSEQ_CLK_NS;
  localparam logic [2:0] EXT_CYC_W = 3'(EXT_CYC);
  logic [4:0] sy;
  logic       sclk_s, cs_s, fs_s, strb_s, sdi_s;
  logic       sclk_p, cs_p, fs_p, strb_p;
  // reset value matches the idle pin levels so no false edge follows reset
  adcseq_sync #(.W(5), .RST_VAL(`ADCSEQ_PIN_IDLE)) u_sync (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .async_in  ({sclk, cs_n, frame_sync, ext_sample_trigger_n, serial_in}),
    .sync_out  (sy)
  );
  assign {sclk_s, cs_s, fs_s, strb_s, sdi_s} = sy;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      sclk_p <= 1'b0;
      cs_p   <= 1'b1;
      fs_p   <= 1'b1;
      strb_p <= 1'b1;
    end else begin
      sclk_p <= sclk_s;
      cs_p   <= cs_s;
      fs_p   <= fs_s;
      strb_p <= strb_s;
    end
  end
  logic sclk_fall, sclk_rise, frame_start, strb_fall, strb_rise;
  assign sclk_fall   = sclk_p && !sclk_s;
  assign sclk_rise   = !sclk_p && sclk_s;
  assign frame_start = (cs_p && !cs_s && fs_s) || (!fs_p && fs_s && !cs_s);
  assign strb_fall   = strb_p && !strb_s;
  assign strb_rise   = !strb_p && strb_s;

  adcseq_pkg::adcseq_state_t st_q;
  logic [11:0] cfg_q;
  logic [5:0]  bit_q;
  logic [15:0] sh_q;
  logic [3:0]  cmd_q;
  logic [2:0]  chan_q;
  logic        ext_q;
  logic [1:0]  exit_q;
  logic        armed_q;
  logic        full_q;
  logic [2:0]  sidx_q;
  logic [3:0]  qcnt_q;
  logic [4:0]  cc_q;
  logic [1:0]  div4_q;
  logic [7:0]  osc_q;
  logic [2:0]  dly_q;
  logic        conv_tick;
  adcseq_pkg::adcseq_mode_t mode;
  assign mode = adcseq_pkg::adcseq_mode_t'(cfg_q[`ADCSEQ_CFG_MODE_HI:`ADCSEQ_CFG_MODE_LO]);
  logic [3:0] qlimit;
  // trigger level: levels 7,5,3,1 filled means 8,6,4,2 results
  assign qlimit = 4'(QDEPTH) - {1'b0, cfg_q[1:0], 1'b0};
  logic [2:0] swp_chan;
  always_comb begin
    case (cfg_q[`ADCSEQ_CFG_SWP_HI:`ADCSEQ_CFG_SWP_LO])
      2'h0:    swp_chan = sidx_q;
      2'h1:    swp_chan = {sidx_q[1:0], 1'b0};
      2'h2:    swp_chan = {sidx_q[2:1], 1'b0};
      default: swp_chan = {1'b0, sidx_q[0], 1'b0};
    endcase
  end
  logic is_sweep;
  assign is_sweep = (mode == adcseq_pkg::MD_SWEEP) || (mode == adcseq_pkg::MD_RSWEEP);
  // conversion clock: oscillator divider or serial clock divided by four
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      osc_q  <= 8'h00;
      div4_q <= 2'h0;
    end else begin
      osc_q <= (osc_q == OSC_DIV) ? 8'h00 : osc_q + 8'h01;
      if (sclk_fall) begin
        div4_q <= div4_q + 2'h1;
      end
    end
  end
  assign conv_tick = cfg_q[`ADCSEQ_CFG_CLKSRC] ? (sclk_fall && div4_q == `ADCSEQ_DIV4)
                                               : (osc_q == OSC_DIV);
  logic start_op;
  logic cmd_done;
  assign cmd_done = (st_q == adcseq_pkg::ST_CMD) && sclk_fall && bit_q == `ADCSEQ_CMD_BITS - 6'h01;
  logic [3:0] cmd_now;
  assign cmd_now = {sh_q[2:0], sdi_s};
  logic in_op;
  assign in_op = (mode != adcseq_pkg::MD_ONE) && armed_q;
  // serial shift and bit count of the frame
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      bit_q <= 6'h00;
      sh_q  <= 16'h0000;
    end else if (frame_start) begin
      bit_q <= 6'h00;
      sh_q  <= 16'h0000;
    end else if (sclk_fall && !cs_s && bit_q != 6'h3F) begin
      bit_q <= bit_q + 6'h01;
      if (bit_q < `ADCSEQ_FRAME_BITS) begin
        sh_q <= {sh_q[14:0], sdi_s};
      end
    end
  end
  // configuration write and hardware default
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cfg_q <= `ADCSEQ_CFG_RESET;
    end else if (cmd_q == `ADCSEQ_CMD_WRITE && sclk_fall && bit_q == `ADCSEQ_FRAME_BITS - 6'h01) begin
      cfg_q <= {sh_q[10:0], sdi_s};
    end else if (cmd_q == `ADCSEQ_CMD_DEFAULT && sclk_fall && bit_q == `ADCSEQ_FRAME_BITS - 6'h01) begin
      cfg_q <= `ADCSEQ_CFG_RESET;
    end
  end
  logic cfg_wr;
  assign cfg_wr = cmd_q == `ADCSEQ_CMD_WRITE && sclk_fall && bit_q == `ADCSEQ_FRAME_BITS - 6'h01;
  logic conv_end;
  assign conv_end = (st_q == adcseq_pkg::ST_CONV) && dly_q == 3'h0 && cc_q == 5'h00;
  logic last_res;
  assign last_res = (qcnt_q + 4'h1 == qlimit);
  // extended sampling entry and exit
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      ext_q  <= 1'b0;
      exit_q <= 2'h0;
    end else if (strb_fall) begin
      ext_q  <= 1'b1;
      exit_q <= 2'h0;
    end else if (ext_q && strb_s && frame_start) begin
      exit_q <= exit_q + 2'h1;
      if (exit_q == 2'h1) begin
        ext_q <= 1'b0;
      end
    end
  end
  // main sequencer
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      st_q    <= adcseq_pkg::ST_IDLE;
      cmd_q   <= 4'h0;
      chan_q  <= 3'h0;
      armed_q <= 1'b0;
      full_q  <= 1'b0;
      sidx_q  <= 3'h0;
      qcnt_q  <= 4'h0;
      cc_q    <= 5'h00;
      dly_q   <= 3'h0;
    end else begin
      if (cfg_wr) begin
        qcnt_q  <= 4'h0;
        full_q  <= 1'b0;
        armed_q <= 1'b0;
        sidx_q  <= 3'h0;
      end
      case (st_q)
        adcseq_pkg::ST_IDLE: begin
          if (frame_start) begin
            st_q <= adcseq_pkg::ST_CMD;
          end else if (strb_fall && armed_q && !(full_q && mode == adcseq_pkg::MD_SWEEP)) begin
            st_q   <= adcseq_pkg::ST_EXT;
            full_q <= 1'b0;
          end
        end
        adcseq_pkg::ST_CMD: begin
          if (cmd_done) begin
            cmd_q <= cmd_now;
            if (cmd_now == `ADCSEQ_CMD_READ) begin
              full_q <= 1'b0;
              qcnt_q <= 4'h0;
              st_q   <= adcseq_pkg::ST_IDLE;
            end else if (cmd_now == `ADCSEQ_CMD_WRITE || cmd_now == `ADCSEQ_CMD_DEFAULT) begin
              st_q <= adcseq_pkg::ST_IDLE;
            end else if ((full_q && mode == adcseq_pkg::MD_SWEEP) || (ext_q && exit_q == 2'h1)) begin
              st_q <= adcseq_pkg::ST_IDLE;
            end else begin
              if (!in_op) begin
                chan_q  <= cmd_now[2:0];
                armed_q <= 1'b1;
                qcnt_q  <= 4'h0;
                sidx_q  <= 3'h0;
                full_q  <= 1'b0;
              end
              st_q <= ext_q ? adcseq_pkg::ST_IDLE : adcseq_pkg::ST_SAMPLE;
            end
          end
        end
        adcseq_pkg::ST_SAMPLE: begin
          if (sclk_fall && bit_q == (cfg_q[`ADCSEQ_CFG_SHORT] ? `ADCSEQ_SHORT_END : `ADCSEQ_LONG_END) - 6'h01) begin
            st_q  <= adcseq_pkg::ST_CONV;
            cc_q  <= CONV_CLKS;
            dly_q <= EXT_CYC_W;
          end
        end
        adcseq_pkg::ST_EXT: begin
          if (strb_rise) begin
            st_q  <= adcseq_pkg::ST_CONV;
            cc_q  <= CONV_CLKS;
            dly_q <= EXT_CYC_W;
          end
        end
        adcseq_pkg::ST_CONV: begin
          if (cc_q != 5'h00) begin
            if (conv_tick) begin
              cc_q <= cc_q - 5'h01;
            end
          end else if (dly_q != 3'h0) begin
            dly_q <= dly_q - 3'h1;
          end else begin
            st_q <= adcseq_pkg::ST_IDLE;
            if (mode == adcseq_pkg::MD_ONE) begin
              armed_q <= 1'b0;
            end else if (last_res) begin
              qcnt_q  <= 4'h0;
              sidx_q  <= 3'h0;
              full_q  <= 1'b1;
              armed_q <= (mode != adcseq_pkg::MD_SWEEP) && ext_q;
            end else begin
              qcnt_q <= qcnt_q + 4'h1;
              sidx_q <= sidx_q + 3'h1;
            end
          end
        end
        default: st_q <= adcseq_pkg::ST_IDLE;
      endcase
    end
  end
  // result hand-off and pin outputs
  logic       buf_ready;
  logic       push_q;
  logic [RES_W-1:0] push_d_q;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      push_q   <= 1'b0;
      push_d_q <= '0;
    end else begin
      if (conv_end) begin
        push_q   <= 1'b1;
        push_d_q <= adc_result;
      end else if (buf_ready) begin
        push_q <= 1'b0;
      end
    end
  end
  logic             bv;
  logic [RES_W-1:0] bd;
  adcseq_buf2 #(.W(RES_W)) u_buf (
    .ref_clk   (ref_clk),
    .rst       (rst),
    .in_valid  (push_q),
    .in_ready  (buf_ready),
    .in_data   (push_d_q),
    .out_valid (bv),
    .out_ready (res_ready || !res_valid),
    .out_data  (bd)
  );
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      res_valid <= 1'b0;
      res_data  <= '0;
    end else if (!res_valid || res_ready) begin
      res_valid <= bv;
      if (bv) begin
        res_data <= bd;
      end
    end
  end
  logic eoc_mode;
  assign eoc_mode = cfg_q[`ADCSEQ_CFG_EOC] && mode == adcseq_pkg::MD_ONE;
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      conversion_done_n <= 1'b1;
      int_n             <= 1'b1;
      sampling          <= 1'b0;
      sample_channel    <= 3'h0;
      cfg_word_out      <= `ADCSEQ_CFG_RESET;
    end else begin
      cfg_word_out   <= cfg_q;
      sampling       <= st_q == adcseq_pkg::ST_SAMPLE || st_q == adcseq_pkg::ST_EXT;
      sample_channel <= is_sweep ? swp_chan : chan_q;
      conversion_done_n <= !(eoc_mode && st_q == adcseq_pkg::ST_CONV && !conv_end);
      if (!eoc_mode && conv_end && (mode == adcseq_pkg::MD_ONE || last_res)) begin
        int_n <= 1'b0;
      end else if (frame_start || strb_fall) begin
        int_n <= 1'b1;
      end
    end
  end
  a_done_in_conv: assert property (@(posedge ref_clk) disable iff (rst)
    !conversion_done_n |-> $past(st_q) == adcseq_pkg::ST_CONV)
    else $error("done low outside conversion");
  a_conv_min_len: assert property (@(posedge ref_clk) disable iff (rst)
    $rose(st_q == adcseq_pkg::ST_CONV) |-> (st_q == adcseq_pkg::ST_CONV) [*3])
    else $error("conversion too short");
  a_sweep_idle: assert property (@(posedge ref_clk) disable iff (rst)
    cmd_done && full_q && mode == adcseq_pkg::MD_SWEEP |=> st_q == adcseq_pkg::ST_IDLE)
    else $error("sweep restarted while queue full");
  a_qcnt_bound: assert property (@(posedge ref_clk) disable iff (rst) qcnt_q < qlimit || qcnt_q == 4'h0)
    else $error("queue count past trigger level");
  a_cfg_clear: assert property (@(posedge ref_clk) disable iff (rst) cfg_wr |=> qcnt_q == 4'h0)
    else $error("queue not cleared on write");
  a_ext_dly: assert property (@(posedge ref_clk) disable iff (rst)
    st_q == adcseq_pkg::ST_EXT && strb_rise |=> st_q == adcseq_pkg::ST_CONV)
    else $error("strobe rise did not start conversion");
  a_no_samp_rd: assert property (@(posedge ref_clk) disable iff (rst)
    cmd_done && cmd_now == `ADCSEQ_CMD_READ |=> st_q == adcseq_pkg::ST_IDLE)
    else $error("queue read started sampling");
  a_int_level: assert property (@(posedge ref_clk) disable iff (rst)
    $fell(int_n) |-> !eoc_mode)
    else $error("interrupt in end-of-conversion mode");
endmodule // adcseq_top

/* File: test/adcseq_host.sv */
// Purpose: host serial port model driving the sequencer pins
// Assumes: chip select starts a frame, or a low frame sync pulse while chip select stays low
// Notes: serial clock stands low outside frames; released data line toggles
`timescale 1ns/10ps
module adcseq_host (
  input  wire logic ref_clk,
  input  wire logic sampling,
  output logic      sclk,
  output logic      cs_n,
  output logic      frame_sync,
  output logic      serial_in,
  output logic      ext_sample_trigger_n
);
  initial begin
    sclk = 1'b0;
    cs_n = 1'b1;
    frame_sync = 1'b1;
    serial_in = 1'b0;
    ext_sample_trigger_n = 1'b1;
  end

  // one frame, msb first, bits change on sclk rise; counts rises seen while sampling
  // strobe falls at rise strb_at; frame sync frames leave chip select low
  task automatic frame(input logic [15:0] word, input int nclk, input int strb_at, input logic fs_mode,
                       output int nsamp);
    nsamp = 0;
    @(posedge ref_clk);
    #1;
    cs_n = 1'b0;
    if (fs_mode) begin
      frame_sync = 1'b0;
      #8 frame_sync = 1'b1;
    end
    for (int i = 0; i < nclk; i++) begin
      #20 sclk = 1'b1;
      serial_in = (i < 16) ? word[15-i] : ~serial_in;
      if (i == strb_at) begin
        ext_sample_trigger_n = 1'b0;
      end
      nsamp += int'(sampling === 1'b1);
      #20 sclk = 1'b0;
    end
    #20 ext_sample_trigger_n = 1'b1;
    if (fs_mode) begin
      frame_sync = 1'b0;
    end else begin
      cs_n = 1'b1;
    end
    serial_in = ~serial_in;
  endtask

  // strobe low for low_cyc clocks, then high
  task automatic strobe(input int low_cyc);
    @(posedge ref_clk);
    #1 ext_sample_trigger_n = 1'b0;
    repeat (low_cyc) @(posedge ref_clk);
    #1 ext_sample_trigger_n = 1'b1;
  endtask
endmodule // adcseq_host

/* File: test/tb_adc_sample_convert_sequencer.sv */
// Purpose: self-checking bench for the sample/convert sequencer
// Assumes: internal oscillator shortened by OSC_DIV
// Notes: results and channels noted in queues, compared by monitors
`timescale 1ns/10ps
module tb_adc_sample_convert_sequencer;
  localparam logic [2:0] SEC [4] = '{3'h1, 3'h2, 3'h0, 3'h2};
  logic        ref_clk;
  logic        rst;
  logic        sclk;
  logic        cs_n;
  logic        frame_sync;
  logic        ext_sample_trigger_n;
  logic        serial_in;
  logic [13:0] adc_result;
  logic        res_ready;
  logic        res_valid;
  logic [13:0] res_data;
  logic [2:0]  sample_channel;
  logic        sampling;
  logic        conversion_done_n;
  logic        int_n;
  logic [11:0] cfg_word_out;
  logic        stall;
  logic        samp_prev;
  int          err_total;
  int          n_checks;
  int          done_cnt;
  int          strb_at;
  logic        fs_mode;
  logic [13:0] exp_q[$];
  logic [2:0]  ch_q[$];

  adcseq_top #(.OSC_DIV(8'h02)) adcseq_top_i (
    .ref_clk(ref_clk), .rst(rst), .sclk(sclk), .cs_n(cs_n), .frame_sync(frame_sync),
    .ext_sample_trigger_n(ext_sample_trigger_n), .serial_in(serial_in), .adc_result(adc_result),
    .res_ready(res_ready), .res_valid(res_valid), .res_data(res_data), .sample_channel(sample_channel),
    .sampling(sampling), .conversion_done_n(conversion_done_n), .int_n(int_n), .cfg_word_out(cfg_word_out));

  adcseq_host adcseq_host_i (
    .ref_clk(ref_clk), .sampling(sampling), .sclk(sclk), .cs_n(cs_n), .frame_sync(frame_sync),
    .serial_in(serial_in), .ext_sample_trigger_n(ext_sample_trigger_n));

  initial ref_clk = 1'b0;
  always #2 ref_clk = ~ref_clk;

  task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // receiver stalls at random, or fully while stall is set
  always @(posedge ref_clk) begin
    #1 res_ready = stall ? 1'b0 : 1'($urandom % 2);
  end

  // result and channel monitors take the oldest note
  always @(negedge ref_clk) begin
    if (conversion_done_n === 1'b0)
      done_cnt++;
    if (res_valid === 1'b1 && res_ready === 1'b1)
      check({2'h0, res_data}, (exp_q.size() > 0) ? {2'h0, exp_q.pop_front()} : 16'hFFFF, "result");
    if (sampling === 1'b1 && samp_prev !== 1'b1)
      check({13'h0, sample_channel}, (ch_q.size() > 0) ? {13'h0, ch_q.pop_front()} : 16'hFFFF, "channel");
    samp_prev = sampling;
  end

  task automatic wr(input logic [11:0] cfg);
    int n;
    adcseq_host_i.frame({4'hA, cfg}, 16, -1, 1'b0, n);
    check(16'(n), 16'h0000, "write samples");
    repeat (50) @(posedge ref_clk);
    check({4'h0, cfg_word_out}, {4'h0, cfg}, "config");
  endtask

  // select frame; a converting one notes its result, then host spaces triggers
  task automatic op(input logic [3:0] cmd, input int nclk, input int exp_s, input bit conv);
    int n;
    if (conv) begin
      adc_result = 14'($urandom);
      exp_q.push_back(adc_result);
    end
    adcseq_host_i.frame({cmd, 12'h000}, nclk, strb_at, fs_mode, n);
    check(16'(n), 16'(exp_s), "sample length");
    repeat (400) @(posedge ref_clk);
  endtask

  initial begin
    #200000;
    err_total++;
    $display("[FAIL] %0t watchdog expired", $time);
    summarize();
  end

  initial begin
    void'($urandom(89));
    rst = 1'b1;
    stall = 1'b0;
    res_ready = 1'b0;
    adc_result = 14'h0000;
    strb_at = -1;
    fs_mode = 1'b0;
    err_total = 0;
    n_checks = 0;
    repeat (4) @(posedge ref_clk);
    #1 rst = 1'b0;
    repeat (5) @(posedge ref_clk);
    check({4'h0, cfg_word_out}, 16'h0800, "reset config");
    check({13'h0, int_n, conversion_done_n, res_valid}, 16'h0006, "reset pins");
    $display("test reset done");
    wr(12'hA04);
    done_cnt = 0;
    ch_q.push_back(3'h3);
    op(4'h3, 16, 12, 1'b1);
    check(16'(done_cnt > 0), 16'h0001, "done low");
    op(4'hE, 16, 0, 1'b0);
    $display("test one shot done");
    wr(12'h800);
    ch_q.push_back(3'h6);
    op(4'h6, 48, 44, 1'b1);
    check({15'h0, int_n}, 16'h0000, "interrupt");
    $display("test long sampling done");
    wr(12'hB00);
    ch_q.push_back(3'h1);
    op(4'h1, 96, 12, 1'b1);
    check({15'h0, int_n}, 16'h0000, "sclk conversion");
    $display("test sclk conversion done");
    wr(12'hA23);
    stall = 1'b1;
    done_cnt = 0;
    ch_q.push_back(3'h5);
    ch_q.push_back(3'h5);
    op(4'h5, 16, 12, 1'b1);
    op(4'h1, 16, 12, 1'b1);
    check({14'h0, int_n, res_valid}, 16'h0001, "repeat end");
    check(16'(done_cnt), 16'h0000, "no eoc");
    stall = 1'b0;
    repeat (50) @(posedge ref_clk);
    $display("test repeat done");
    wr(12'hA4A);
    for (int k = 0; k < 4; k++) begin
      ch_q.push_back(3'(2 * k));
      op(4'h7, 16, 12, 1'b1);
    end
    op(4'h7, 16, 0, 1'b0);
    check(16'(ch_q.size()), 16'h0000, "sweep channels");
    $display("test sweep done");
    for (int p = 0; p < 4; p++) begin
      wr(12'hA63 | 12'(p << 3));
      for (int k = 0; k < 4; k++) begin
        ch_q.push_back(((k % 2) == 0) ? 3'h0 : SEC[p]);
        op(4'h4, 16, 12, 1'b1);
      end
    end
    wr(12'hA23);
    strb_at = 10;
    fs_mode = 1'b1;
    ch_q.push_back(3'h2);
    op(4'h2, 16, 12, 1'b1);
    for (int k = 0; k < 2; k++) begin
      ch_q.push_back(3'h2);
      adc_result = 14'($urandom);
      exp_q.push_back(adc_result);
      adcseq_host_i.strobe(20);
      repeat (400) @(posedge ref_clk);
      check({15'h0, int_n}, 16'(k), "strobe repeat");
    end
    $display("test strobe done");
    repeat (100) @(posedge ref_clk);
    check(16'(exp_q.size() + ch_q.size()), 16'h0000, "all results");
    $display("test repeat sweep done");
    summarize();
  end
endmodule // tb_adc_sample_convert_sequencer
